// ### link_status_map.vh
`ifndef LINK_STATUS_MAP_VH
`define LINK_STATUS_MAP_VH

// Register offsets (byte addresses on the plain register port)
`define ADDR_STATUS        8'h00
`define ADDR_EVENT         8'h04
`define ADDR_MASK          8'h08
`define ADDR_STATUS_WIDTH  8

// Status register field positions
`define STAT_RATE_BIT      0
`define STAT_WIDTH_LO      1
`define STAT_REV_LO        3
`define STAT_UP_BIT        5
`define STAT_STATE_LO      8

// Event bits
`define EV_RATE            0
`define EV_WIDTH           1
`define EV_STATE           2
`define EV_REV             3
`define EV_UP              4
`define EV_DOWN            5
`define EV_COUNT           6

// Reset values
`define RST_RATE           1'b0
`define RST_WIDTH          2'h0
`define RST_STATE          6'h00
`define RST_REV            2'h0
`define RST_UP_N           1'b1
`define RST_MASK           6'h00

// Link rate and width codes
`define RATE_2G5           1'b0
`define RATE_5G0           1'b1
`define WIDTH_X1           2'h0
`define WIDTH_X2           2'h1
`define WIDTH_X4           2'h2
`define WIDTH_X8           2'h3

// Training state codes of note
`define TS_DETECT_QUIET    6'h00
`define TS_POLL_ACTIVE     6'h04
`define TS_CFG_IDLE        6'h15
`define TS_L0              6'h16

`endif

// ### link_status_reporting.v
// Operation
// - Rate output: 0 means 2.5 GB/s, 1 means 5.0 GB/s.
// - Rate output comes from its own flop to steer the clock mux.
// - Two-bit width code: 00 x1, 01 x2, 10 x4, 11 x8.
// - Six-bit training state code, e.g. 000000, 000100, 010101.
// - Lane reversal code: 00 none, 01 1:0, 10 3:0, 11 7:0.
// - Link-up output is low while the physical link is up.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "link_status_map.vh"
module link_status_reporting (
  input  wire        clock,               // Pipe clock, 25 MHz
  input  wire        sys_rst,             // Async reset, active high
  input  wire        phy_rate_fast,       // Physical layer runs at 5.0 GB/s
  input  wire [1:0]  phy_width_code,      // Negotiated width from the physical layer
  input  wire [5:0]  phy_training_state,  // Training state machine state
  input  wire [1:0]  phy_reversal_code,   // Lane reversal from the physical layer
  input  wire        phy_link_up,         // Physical link is up
  input  wire [7:0]  reg_addr,            // Register address
  input  wire [31:0] reg_wdata,           // Register write data
  input  wire        reg_wr,              // Write strobe
  input  wire        reg_rd,              // Read strobe
  output reg  [31:0] reg_rdata,           // Read data, cycle after strobe
  output reg         current_link_rate,   // Link rate select
  output reg  [1:0]  current_link_width,  // Link width code
  output reg  [5:0]  training_state_code, // Training state code
  output reg  [1:0]  lane_reversal_code,  // Lane reversal code
  output reg         phy_link_up_n,       // Link up, active low
  output reg         irq                  // Level interrupt
);

  // Held fields and their change pulses
  wire [1:0]           width_held;
  wire [5:0]           state_held;
  wire [1:0]           rev_held;
  wire                 width_chg;
  wire                 state_chg;
  wire                 rev_chg;

  // Last samples for the rate and link-up edge detectors
  reg                  rate_prev_reg;
  reg                  up_prev_reg;
  wire                 rate_moved;
  wire                 link_rise;
  wire                 link_fall;

  // Event, mask and register port state
  reg  [`EV_COUNT-1:0] event_reg;
  reg  [`EV_COUNT-1:0] mask_reg;
  reg  [`EV_COUNT-1:0] event_next;
  reg  [`EV_COUNT-1:0] mask_next;
  reg  [`EV_COUNT-1:0] hit;
  wire [`EV_COUNT-1:0] pending;
  reg  [31:0]          status_word;
  reg  [31:0]          rd_word;
  wire                 event_wr;
  wire                 mask_wr;

  // Zero bits above the event field in a read word
  localparam PAD_BITS = 32 - `EV_COUNT;

  // Width field with its change flag
  status_capture #(.WIDTH(2), .RESET_VALUE(`RST_WIDTH)) u_width (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .value_in   (phy_width_code),
    .value_reg  (width_held),
    .change_reg (width_chg)
  );

  // Training state field with its change flag
  status_capture #(.WIDTH(6), .RESET_VALUE(`RST_STATE)) u_state (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .value_in   (phy_training_state),
    .value_reg  (state_held),
    .change_reg (state_chg)
  );

  // Lane reversal field with its change flag
  status_capture #(.WIDTH(2), .RESET_VALUE(`RST_REV)) u_rev (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .value_in   (phy_reversal_code),
    .value_reg  (rev_held),
    .change_reg (rev_chg)
  );

  // Dedicated rate flop, kept apart so it can drive the global_clock_mux
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      current_link_rate <= `RST_RATE;
    end else begin
      current_link_rate <= phy_rate_fast ? `RATE_5G0 : `RATE_2G5;
    end
  end

  // Output copies of the held fields
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      current_link_width  <= `RST_WIDTH;
      training_state_code <= `RST_STATE;
      lane_reversal_code  <= `RST_REV;
    end else begin
      current_link_width  <= width_held;
      training_state_code <= state_held;
      lane_reversal_code  <= rev_held;
    end
  end

  // Active-low link-up flop, low while the link is up
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phy_link_up_n <= `RST_UP_N;
    end else begin
      phy_link_up_n <= ~phy_link_up;
    end
  end

  // Edge history for the rate and link-up events
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rate_prev_reg <= `RST_RATE;
      up_prev_reg   <= 1'b0;
    end else begin
      rate_prev_reg <= current_link_rate;
      up_prev_reg   <= phy_link_up;
    end
  end

  // Edges of the link-up input against its last sample
  assign link_rise = phy_link_up & ~up_prev_reg;
  assign link_fall = ~phy_link_up & up_prev_reg;

  // Rate moved when the dedicated flop differs from its last copy
  assign rate_moved = current_link_rate ^ rate_prev_reg;

  // Register write strobes decoded once
  assign event_wr = reg_wr && (reg_addr == `ADDR_EVENT);
  assign mask_wr  = reg_wr && (reg_addr == `ADDR_MASK);

  // Events raised this cycle
  always @* begin
    hit = {`EV_COUNT{1'b0}};
    hit[`EV_RATE]  = rate_moved;
    hit[`EV_WIDTH] = width_chg;
    hit[`EV_STATE] = state_chg;
    hit[`EV_REV]   = rev_chg;
    hit[`EV_UP]    = link_rise;
    hit[`EV_DOWN]  = link_fall;
  end

  // Sticky events: write one to clear, a new event wins over the clear
  always @* begin
    event_next = event_reg;
    if (event_wr) begin
      event_next = event_reg & ~reg_wdata[`EV_COUNT-1:0];
    end
    event_next = event_next | hit;
  end

  // Mask takes the written value, so the interrupt follows it at once
  always @* begin
    mask_next = mask_reg;
    if (mask_wr) begin
      mask_next = reg_wdata[`EV_COUNT-1:0];
    end
  end

  // Events that may raise the interrupt after this edge
  assign pending = event_next & mask_next;

  // Live status word
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`STAT_RATE_BIT]               = current_link_rate;
    status_word[`STAT_WIDTH_LO+1:`STAT_WIDTH_LO] = current_link_width;
    status_word[`STAT_REV_LO+1:`STAT_REV_LO]     = lane_reversal_code;
    status_word[`STAT_UP_BIT]                 = ~phy_link_up_n;
    status_word[`STAT_STATE_LO+5:`STAT_STATE_LO] = training_state_code;
  end

  // Read multiplexer, zero for addresses with nothing behind them
  always @* begin
    rd_word = 32'h0000_0000;
    case (reg_addr)
      `ADDR_STATUS: rd_word = status_word;
      `ADDR_EVENT:  rd_word = {{PAD_BITS{1'b0}}, event_reg};
      `ADDR_MASK:   rd_word = {{PAD_BITS{1'b0}}, mask_reg};
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  // Event and mask registers
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      event_reg <= {`EV_COUNT{1'b0}};
      mask_reg  <= `RST_MASK;
    end else begin
      event_reg <= event_next;
      mask_reg  <= mask_next;
    end
  end

  // Level interrupt, high while an unmasked event is held
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |pending;
    end
  end

  // Read data stand for the one cycle after the strobe, zero otherwise
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_word;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // link_status_reporting

// ### link_status_reporting_sva.sv
`timescale 1ns/1ps
module link_status_reporting_sva (
  input wire        clock,               // Pipe clock
  input wire        sys_rst,             // Reset
  input wire        phy_rate_fast,       // Rate in
  input wire [1:0]  phy_width_code,      // Width in
  input wire [5:0]  phy_training_state,  // State in
  input wire [1:0]  phy_reversal_code,   // Reversal in
  input wire        phy_link_up,         // Link up in
  input wire [7:0]  reg_addr,            // Address
  input wire        reg_rd,              // Read strobe
  input wire [31:0] reg_rdata,           // Read data
  input wire        current_link_rate,   // Rate out
  input wire [1:0]  current_link_width,  // Width out
  input wire [5:0]  training_state_code, // State out
  input wire [1:0]  lane_reversal_code,  // Reversal out
  input wire        phy_link_up_n        // Link up out
);
  logic [1:0] up_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Cycles since reset, so the pipeline is full
  always @(posedge clock or posedge sys_rst)
    if (sys_rst) up_cnt <= 2'h0;
    else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
  rate_follow_a: assert property (up_cnt != 0 |-> current_link_rate == $past(phy_rate_fast))
    else $error("rate output lag wrong");
  rate_hold_a: assert property (up_cnt[1] && $past(phy_rate_fast) == $past(phy_rate_fast, 2) |-> $stable(current_link_rate))
    else $error("rate output moved");
  width_lag_a: assert property (up_cnt[1] |-> current_link_width == $past(phy_width_code, 2))
    else $error("width output wrong");
  state_lag_a: assert property (up_cnt[1] |-> training_state_code == $past(phy_training_state, 2))
    else $error("state output wrong");
  rev_lag_a: assert property (up_cnt[1] |-> lane_reversal_code == $past(phy_reversal_code, 2))
    else $error("reversal output wrong");
  link_low_a: assert property (up_cnt != 0 |-> phy_link_up_n == !$past(phy_link_up))
    else $error("link up output wrong");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0c |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // link_status_reporting_sva
bind link_status_reporting link_status_reporting_sva link_status_reporting_sva_i (.*);

// ### link_status_reporting_tb.sv
`timescale 1ns/1ps
module link_status_reporting_tb;
  logic clock = 0, sys_rst = 1, phy_rate_fast = 0, phy_link_up = 0, reg_wr = 0, reg_rd = 0;
  logic [1:0] phy_width_code = 0, phy_reversal_code = 0;
  logic [5:0] phy_training_state = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, rd_seen;
  logic [11:0] p;
  wire [31:0] reg_rdata;
  wire current_link_rate, phy_link_up_n, irq, link_seen;
  wire [1:0] current_link_width, lane_reversal_code;
  wire [5:0] training_state_code;
  wire [11:0] outs = {current_link_rate, current_link_width, training_state_code, lane_reversal_code, phy_link_up_n};
  int err_total = 0, checks_done = 0;
  // Rows: inputs {rate,width,state,rev,up} beside expected outputs
  logic [23:0] rows [4] = '{24'h000001, 24'ha23a22, 24'h4ad4ac, 24'heb6eb7};
  link_status_reporting link_status_reporting_i (
    .clock               (clock),
    .sys_rst             (sys_rst),
    .phy_rate_fast       (phy_rate_fast),
    .phy_width_code      (phy_width_code),
    .phy_training_state  (phy_training_state),
    .phy_reversal_code   (phy_reversal_code),
    .phy_link_up         (phy_link_up),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .current_link_rate   (current_link_rate),
    .current_link_width  (current_link_width),
    .training_state_code (training_state_code),
    .lane_reversal_code  (lane_reversal_code),
    .phy_link_up_n       (phy_link_up_n),
    .irq                 (irq)
  );
  link_user link_user_i (.clock(clock), .phy_link_up_n(phy_link_up_n), .link_seen(link_seen));
  initial forever #20 clock = ~clock;
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task drive(input logic [11:0] v);
    @(posedge clock);
    {phy_rate_fast, phy_width_code, phy_training_state, phy_reversal_code, phy_link_up} <= v;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock); reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
    @(posedge clock); reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock); reg_addr <= a; reg_rd <= 1;
    @(posedge clock); reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100000 err_total++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    #1 chk("reset outputs", 32'h1, outs);
    chk("reset irq", 32'h0, irq);
    chk("reset read data", 32'h0, reg_rdata);
    $display("reset test done");
    @(posedge clock) sys_rst <= 0;
    foreach (rows[i]) begin
      p = rows[i][23:12];
      drive(p);
      repeat (3) @(posedge clock);
      #1 chk("status outputs", rows[i][11:0], outs);
      chk("user link seen", p[0], link_seen);
      rd(8'h00, rd_seen);
      chk("status word", {18'h0, p[8:3], 2'b0, p[0], p[2:1], p[10:9], p[11]}, rd_seen);
      $display("row %0d done", i);
    end
    rd(8'h0c, rd_seen);
    chk("unmapped read", 32'h0, rd_seen);
    $display("unmapped test done");
    wr(8'h04, 32'h3f);
    wr(8'h08, 32'h2);
    drive(12'h8b6);
    @(posedge clock) #1 chk("width held", 32'h3, current_link_width);
    repeat (3) @(posedge clock);
    #1 chk("irq raised", 32'h1, irq);
    rd(8'h04, rd_seen);
    chk("event word", 32'h2, rd_seen);
    wr(8'h04, 32'h2);
    drive(12'h0b6);
    wr(8'h04, 32'h1);
    repeat (3) @(posedge clock);
    #1 chk("irq masked", 32'h0, irq);
    chk("rate low", 32'h0, current_link_rate);
    rd(8'h04, rd_seen);
    chk("rate event over clear", 32'h1, rd_seen);
    $display("irq test done");
    drive(12'h0b7);
    repeat (3) @(posedge clock);
    rd(8'h04, rd_seen);
    chk("link up event", 32'h11, rd_seen);
    wr(8'h04, 32'h3f);
    drive(12'h020);
    repeat (3) @(posedge clock);
    rd(8'h04, rd_seen);
    chk("state rev down events", 32'h2c, rd_seen);
    rd(8'h08, rd_seen);
    chk("mask readback", 32'h2, rd_seen);
    $display("event test done");
    @(posedge clock) sys_rst <= 1;
    repeat (2) @(posedge clock);
    #1 chk("mid reset outputs", 32'h1, outs);
    chk("mid reset irq", 32'h0, irq);
    @(posedge clock) sys_rst <= 0;
    rd(8'h08, rd_seen);
    chk("mask after reset", 32'h0, rd_seen);
    repeat (3) @(posedge clock);
    #1 chk("outputs after reset", 32'h21, outs);
    $display("mid reset test done");
    end_sim();
  end
endmodule // link_status_reporting_tb

// ### link_user.sv
`timescale 1ns/1ps
// User logic that watches the link-up flag
module link_user (
  input  wire  clock,         // Pipe clock
  input  wire  phy_link_up_n, // Link up, active low
  output logic link_seen      // Link seen up
);
  // Low on the flag means the link is up
  always @(posedge clock) link_seen <= !phy_link_up_n;
endmodule // link_user

// ### status_capture.v
`timescale 1ns/1ps
// Holds one status field in its own flop and flags a change
module status_capture #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input  wire             clock,     // Pipe clock
  input  wire             sys_rst,   // Async reset, active high
  input  wire [WIDTH-1:0] value_in,  // Live condition from the physical layer
  output reg  [WIDTH-1:0] value_reg, // Held value
  output reg              change_reg // One-cycle pulse on a change
);

  // Load on every pipe clock edge, pulse when the value moves
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      value_reg  <= RESET_VALUE;
      change_reg <= 1'b0;
    end else begin
      value_reg  <= value_in;
      change_reg <= (value_in != value_reg);
    end
  end

endmodule // status_capture
